// ### inc/serial0_rate_gen_pkg.sv
/*
  constants, register offsets and port function codes for the serial port 0
  rate generator. assumes an 8-bit special function register bus with pages.
*/
package serial0_rate_gen_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] SERIAL0_RATE_GEN_ADDR_RELOAD = 8'h9a;
  localparam logic [7:0] SERIAL0_RATE_GEN_ADDR_COUNTER = 8'h9b;
  localparam logic [7:0] SERIAL0_RATE_GEN_ADDR_AUX6 = 8'ha4;
  localparam logic [7:0] SERIAL0_RATE_GEN_ADDR_CTRL1 = 8'hb9;
  localparam logic [3:0] SERIAL0_RATE_GEN_PAGE_BASE = 4'h0;
  localparam logic [3:0] SERIAL0_RATE_GEN_PAGE_AUX6 = 4'h3;

  // values after reset
  localparam logic [7:0] SERIAL0_RATE_GEN_RST_RELOAD = 8'h00;
  localparam logic [7:0] SERIAL0_RATE_GEN_RST_COUNTER = 8'h00;
  localparam logic [7:0] SERIAL0_RATE_GEN_RST_AUX6 = 8'h00;
  localparam logic [7:0] SERIAL0_RATE_GEN_RST_CTRL1 = 8'h00;
  localparam logic [7:0] SERIAL0_RATE_GEN_RST_MASK = 8'h00;

  // control register 1 field positions
  localparam int SERIAL0_RATE_GEN_BIT_RUN = 7;
  localparam int SERIAL0_RATE_GEN_BIT_FAST = 6;
  localparam int SERIAL0_RATE_GEN_BIT_TXSEL = 5;
  localparam int SERIAL0_RATE_GEN_BIT_RXSEL = 4;
  localparam int SERIAL0_RATE_GEN_BIT_CKOE = 3;
  localparam int SERIAL0_RATE_GEN_BIT_AUTO_REP = 2;
  localparam logic [7:0] SERIAL0_RATE_GEN_CTRL1_WMASK = 8'hfc;

  // clock division counts
  localparam logic [3:0] SERIAL0_RATE_GEN_DIV12_LAST = 4'hb;
  localparam logic [5:0] SERIAL0_RATE_GEN_DIV64_MASK = 6'h3f;
  localparam logic [5:0] SERIAL0_RATE_GEN_DIV4_MASK = 6'h03;
  localparam logic [7:0] SERIAL0_RATE_GEN_COUNT_FULL = 8'hff;

  // three-bit mode codes
  localparam logic [2:0] SERIAL0_RATE_GEN_MODE_SHIFT = 3'b000;
  localparam logic [2:0] SERIAL0_RATE_GEN_MODE_UART8 = 3'b001;
  localparam logic [2:0] SERIAL0_RATE_GEN_MODE_UART9F = 3'b010;
  localparam logic [2:0] SERIAL0_RATE_GEN_MODE_UART9T = 3'b011;
  localparam logic [2:0] SERIAL0_RATE_GEN_MODE_SPI = 3'b100;
  localparam logic [2:0] SERIAL0_RATE_GEN_MODE_LIN = 3'b101;

  // function the port runs in, decoded from mode and clock selects
  typedef enum logic [2:0] {
    SERIAL0_RATE_GEN_FN_SHIFT,
    SERIAL0_RATE_GEN_FN_UART8,
    SERIAL0_RATE_GEN_FN_UART9,
    SERIAL0_RATE_GEN_FN_SPI,
    SERIAL0_RATE_GEN_FN_TIMER,
    SERIAL0_RATE_GEN_FN_LIN,
    SERIAL0_RATE_GEN_FN_RESERVED
  } serial0_rate_gen_fn_t;

endpackage : serial0_rate_gen_pkg

// ### logic/serial0_rate_gen_top.sv
/*
  serial port 0 rate generator: reload counter, clock source select, clock
  output, shared register decode and per-direction time base selection.
  assumes the cpu drives the register bus in the clk_i domain, and that the
  configuration bits, mode bits and timer overflow come from same-clock logic.
*/
// Summary of operation
// - access select maps 0xB9 to control 1
// - run bit starts counting, reset stopped
// - fast bit picks clock, else divide twelve
// - bit 5 routes overflow to transmit
// - bit 4 routes overflow to receive
// - bit 3 enables the clock output pin
// - clock output toggles on every overflow
// - bit 2 enables auto repeat transmit
// - eight-bit up counter plus reload, zero reset
// - overflow reloads counter and gives time base
// - reload write hits counter only while stopped
// - counter writable, never alters reload
// - overflow always offered to other peripherals
// - mode 010 unselected: fixed sysclk divider
// - uart modes select overflow per direction
// - mode 010 one select: other fixed divider
// - mode 101 both selects: bus, auto baud
`timescale 1ns/1ps
module serial0_rate_gen_top
  import serial0_rate_gen_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // special function register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [3:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // serial port 0 configuration from neighbouring registers
  input wire logic ctrl1_access_sel_i,
  input wire logic mode_bit_hi_i,
  input wire logic mode_bit_mid_i,
  input wire logic mode_bit_lo_i,
  input wire logic baud_double_i,
  input wire logic baud_extra_double_i,
  input wire logic shift_fast_sel_i,
  input wire logic timer_ovf_i,
  // time base towards the serial engine and peripherals
  output logic rate_gen_overflow_o,
  output logic tx_tick_o,
  output logic rx_tick_o,
  output serial0_rate_gen_fn_t port_fn_o,
  output logic auto_repeat_tx_en_o,
  output logic auto_baud_en_o,
  // clock output pin
  output logic clk_out_pin_o,
  output logic clk_out_oe_o,
  // auxiliary pin select register contents
  output logic [7:0] aux_pin_select_six_o
);

  logic [7:0] ctrl1_q, mask_q, aux6_q, reload_q, count_q, rdata_q;
  logic [3:0] pre12_q;
  logic [5:0] free_q;
  logic ovf_q, toggle_q, tx_q, rx_q, abaud_q;
  serial0_rate_gen_fn_t fn_q;

  logic run, fast, tx_sel, rx_sel;
  logic div12_en, gen_tick;
  logic wr_reload, wr_counter, wr_shared, wr_aux6;
  logic fixed_tick, shift_tick;
  logic [2:0] mode;
  logic [5:0] fixed_mask;
  logic [1:0] dbl_sum;
  logic tx_d, rx_d;
  serial0_rate_gen_fn_t fn_d;

  assign run = ctrl1_q[SERIAL0_RATE_GEN_BIT_RUN];
  assign fast = ctrl1_q[SERIAL0_RATE_GEN_BIT_FAST];
  assign tx_sel = ctrl1_q[SERIAL0_RATE_GEN_BIT_TXSEL];
  assign rx_sel = ctrl1_q[SERIAL0_RATE_GEN_BIT_RXSEL];
  assign mode = {mode_bit_hi_i, mode_bit_mid_i, mode_bit_lo_i};

  // register write decode; the shared address is steered by access select
  assign wr_reload = sfr_wr_i && sfr_page_i == SERIAL0_RATE_GEN_PAGE_BASE && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_RELOAD;
  assign wr_counter = sfr_wr_i && sfr_page_i == SERIAL0_RATE_GEN_PAGE_BASE && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_COUNTER;
  assign wr_shared = sfr_wr_i && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_CTRL1;
  assign wr_aux6 = sfr_wr_i && sfr_page_i == SERIAL0_RATE_GEN_PAGE_AUX6 && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_AUX6;

  // control register 1; reserved low bits never stored, so they read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl1_q <= SERIAL0_RATE_GEN_RST_CTRL1;
    end else if (wr_shared && ctrl1_access_sel_i) begin
      ctrl1_q <= sfr_wdata_i & SERIAL0_RATE_GEN_CTRL1_WMASK;
    end
  end

  // address mask register behind the same address
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= SERIAL0_RATE_GEN_RST_MASK;
    end else if (wr_shared && !ctrl1_access_sel_i) begin
      mask_q <= sfr_wdata_i;
    end
  end

  // auxiliary pin select register, stored only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aux6_q <= SERIAL0_RATE_GEN_RST_AUX6;
    end else if (wr_aux6) begin
      aux6_q <= sfr_wdata_i;
    end
  end

  // prescalers: divide by twelve for the generator, free count for fixed rates
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre12_q <= 4'h0;
      free_q <= 6'h00;
    end else begin
      pre12_q <= (pre12_q == SERIAL0_RATE_GEN_DIV12_LAST) ? 4'h0 : pre12_q + 4'h1;
      free_q <= free_q + 6'h01;
    end
  end

  assign div12_en = pre12_q == SERIAL0_RATE_GEN_DIV12_LAST;
  assign gen_tick = run && (fast || div12_en);

  // reload register; the counter never writes it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reload_q <= SERIAL0_RATE_GEN_RST_RELOAD;
    end else if (wr_reload) begin
      reload_q <= sfr_wdata_i;
    end
  end

  // up counter; a cpu write wins over a tick landing in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_q <= SERIAL0_RATE_GEN_RST_COUNTER;
    end else if (wr_counter) begin
      count_q <= sfr_wdata_i;
    end else if (wr_reload && !run) begin
      count_q <= sfr_wdata_i;
    end else if (gen_tick) begin
      if (count_q == SERIAL0_RATE_GEN_COUNT_FULL) begin
        count_q <= reload_q;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // overflow pulse; a write over a wrapping count suppresses it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= gen_tick && count_q == SERIAL0_RATE_GEN_COUNT_FULL && !wr_counter && !(wr_reload && !run);
    end
  end

  // halved overflow rate for the clock pin; keeps running with pin disabled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      toggle_q <= 1'b0;
    end else if (ovf_q) begin
      toggle_q <= !toggle_q;
    end
  end

  // fixed rate: sysclk/64; double halves it, extra double quarters it, both give /8
  assign dbl_sum = {baud_extra_double_i, baud_double_i};
  assign fixed_mask = SERIAL0_RATE_GEN_DIV64_MASK >> dbl_sum;
  assign fixed_tick = (free_q & fixed_mask) == 6'h00;
  assign shift_tick = shift_fast_sel_i ? ((free_q & SERIAL0_RATE_GEN_DIV4_MASK) == 6'h00) : div12_en;

  // time base selection per direction from mode and the two selects
  always_comb begin
    tx_d = 1'b0;
    rx_d = 1'b0;
    fn_d = SERIAL0_RATE_GEN_FN_RESERVED;
    unique case (mode)
      SERIAL0_RATE_GEN_MODE_SHIFT, SERIAL0_RATE_GEN_MODE_SPI: begin
        // one shift clock serves both directions
        tx_d = tx_sel ? ovf_q : shift_tick;
        rx_d = tx_d;
        fn_d = (mode == SERIAL0_RATE_GEN_MODE_SHIFT) ? SERIAL0_RATE_GEN_FN_SHIFT : SERIAL0_RATE_GEN_FN_SPI;
        if (rx_sel) begin
          tx_d = 1'b0;
          rx_d = 1'b0;
          fn_d = SERIAL0_RATE_GEN_FN_RESERVED;
        end
      end
      SERIAL0_RATE_GEN_MODE_UART8, SERIAL0_RATE_GEN_MODE_UART9T: begin
        tx_d = tx_sel ? ovf_q : timer_ovf_i;
        rx_d = rx_sel ? ovf_q : timer_ovf_i;
        fn_d = (mode == SERIAL0_RATE_GEN_MODE_UART8) ? SERIAL0_RATE_GEN_FN_UART8 : SERIAL0_RATE_GEN_FN_UART9;
      end
      SERIAL0_RATE_GEN_MODE_UART9F: begin
        if (tx_sel && rx_sel) begin
          fn_d = SERIAL0_RATE_GEN_FN_TIMER; // generator runs alone, no serial ticks
        end else begin
          tx_d = tx_sel ? ovf_q : fixed_tick;
          rx_d = rx_sel ? ovf_q : fixed_tick;
          fn_d = SERIAL0_RATE_GEN_FN_UART9;
        end
      end
      SERIAL0_RATE_GEN_MODE_LIN: begin
        if (tx_sel && rx_sel) begin
          tx_d = ovf_q;
          rx_d = ovf_q;
          fn_d = SERIAL0_RATE_GEN_FN_LIN;
        end
      end
      default: begin
        fn_d = SERIAL0_RATE_GEN_FN_RESERVED;
      end
    endcase
  end

  // registered serial ticks and decoded function
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_q <= 1'b0;
      rx_q <= 1'b0;
      fn_q <= SERIAL0_RATE_GEN_FN_SHIFT;
      abaud_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      fn_q <= fn_d;
      abaud_q <= fn_d == SERIAL0_RATE_GEN_FN_LIN;
    end
  end

  // read data is registered; unmapped addresses answer zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_i) begin
      rdata_q <= 8'h00;
      if (sfr_page_i == SERIAL0_RATE_GEN_PAGE_BASE && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_RELOAD) begin
        rdata_q <= reload_q;
      end
      if (sfr_page_i == SERIAL0_RATE_GEN_PAGE_BASE && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_COUNTER) begin
        rdata_q <= count_q;
      end
      if (sfr_page_i == SERIAL0_RATE_GEN_PAGE_AUX6 && sfr_addr_i == SERIAL0_RATE_GEN_ADDR_AUX6) begin
        rdata_q <= aux6_q;
      end
      if (sfr_addr_i == SERIAL0_RATE_GEN_ADDR_CTRL1) begin
        rdata_q <= ctrl1_access_sel_i ? ctrl1_q : mask_q;
      end
    end
  end

  // outputs, all from flip-flops
  assign sfr_rdata_o = rdata_q;
  assign rate_gen_overflow_o = ovf_q;
  assign tx_tick_o = tx_q;
  assign rx_tick_o = rx_q;
  assign port_fn_o = fn_q;
  assign auto_repeat_tx_en_o = ctrl1_q[SERIAL0_RATE_GEN_BIT_AUTO_REP];
  assign auto_baud_en_o = abaud_q;
  assign clk_out_pin_o = toggle_q;
  assign clk_out_oe_o = ctrl1_q[SERIAL0_RATE_GEN_BIT_CKOE];
  assign aux_pin_select_six_o = aux6_q;

  // no cpu write to the counter in a cycle
  logic no_cnt_wr;
  assign no_cnt_wr = !wr_counter && !(wr_reload && !run);

  sequence s_wrap;
    gen_tick && count_q == SERIAL0_RATE_GEN_COUNT_FULL && no_cnt_wr;
  endsequence

  sequence s_reloaded;
    count_q == $past(reload_q) && ovf_q;
  endsequence

  property p_ctrl1_map;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_shared && ctrl1_access_sel_i |=> ctrl1_q == ($past(sfr_wdata_i) & SERIAL0_RATE_GEN_CTRL1_WMASK) && $stable(mask_q);
  endproperty
  a_ctrl1_map: assert property (p_ctrl1_map) else $error("shared address did not reach control 1");
  property p_stopped_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !run && no_cnt_wr |=> $stable(count_q);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("counter moved while stopped");
  property p_slow_tick;
    @(posedge clk_i) disable iff (sys_rst_i)
      gen_tick && !fast |=> !gen_tick [*8];
  endproperty
  a_slow_tick: assert property (p_slow_tick) else $error("slow clock ticked too often");
  property p_fast_tick;
    @(posedge clk_i) disable iff (sys_rst_i)
      run && fast && count_q != SERIAL0_RATE_GEN_COUNT_FULL && no_cnt_wr |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("fast clock missed a step");
  property p_wrap;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_wrap |=> s_reloaded;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow did not reload");
  property p_reload_stopped;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_reload && !run && !wr_counter |=> count_q == $past(sfr_wdata_i) && reload_q == $past(sfr_wdata_i);
  endproperty
  a_reload_stopped: assert property (p_reload_stopped) else $error("stopped reload write missed counter");
  property p_reload_running;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_reload && run && !wr_counter && !gen_tick |=> $stable(count_q);
  endproperty
  a_reload_running: assert property (p_reload_running) else $error("running reload write hit counter");
  property p_counter_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_counter && !wr_reload |=> $stable(reload_q) && count_q == $past(sfr_wdata_i);
  endproperty
  a_counter_write: assert property (p_counter_write) else $error("counter write disturbed reload");
  property p_clk_toggle;
    @(posedge clk_i) disable iff (sys_rst_i)
      ovf_q |=> clk_out_pin_o != $past(clk_out_pin_o);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("clock output failed to toggle");
  property p_uart_tx;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mode == SERIAL0_RATE_GEN_MODE_UART8 || mode == SERIAL0_RATE_GEN_MODE_UART9T) && tx_sel |=> tx_tick_o == $past(ovf_q);
  endproperty
  a_uart_tx: assert property (p_uart_tx) else $error("transmit tick not from generator");
  property p_split_rx;
    @(posedge clk_i) disable iff (sys_rst_i)
      mode == SERIAL0_RATE_GEN_MODE_UART9F && tx_sel && !rx_sel |=> rx_tick_o == $past(fixed_tick) && tx_tick_o == $past(ovf_q);
  endproperty
  a_split_rx: assert property (p_split_rx) else $error("split clocking wrong");
  property p_fixed_rate;
    @(posedge clk_i) disable iff (sys_rst_i)
      mode == SERIAL0_RATE_GEN_MODE_UART9F && !tx_sel && !rx_sel |=> tx_tick_o == $past(fixed_tick) && rx_tick_o == tx_tick_o;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate mode wrong tick");
  property p_lin;
    @(posedge clk_i) disable iff (sys_rst_i)
      mode == SERIAL0_RATE_GEN_MODE_LIN && tx_sel && rx_sel |=> auto_baud_en_o && rx_tick_o == $past(ovf_q);
  endproperty
  a_lin: assert property (p_lin) else $error("bus mode not set up");

endmodule : serial0_rate_gen_top

// ### tb/serial0_rate_gen_port_model.sv
/*
  far-side model: serial engine and peripheral clock consumers of the rate
  generator. assumes one-cycle pulses in the clk_i domain.
*/
`timescale 1ns/1ps
module serial0_rate_gen_port_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // time base from the generator
  input wire logic ovf_i,
  input wire logic tx_tick_i,
  input wire logic rx_tick_i,
  input wire logic clk_out_pin_i,
  // running totals for the bench
  output int n_ovf_o,
  output int n_tx_o,
  output int n_rx_o,
  output int n_clk_o
);
  logic clk_out_q;

  // consumers only count; the engine never pushes back on its time base
  always_ff @(posedge clk_i) begin
    clk_out_q <= clk_out_pin_i;
    if (sys_rst_i) begin
      n_ovf_o <= 0;
      n_tx_o <= 0;
      n_rx_o <= 0;
      n_clk_o <= 0;
    end else begin
      n_ovf_o <= n_ovf_o + int'(ovf_i);
      n_tx_o <= n_tx_o + int'(tx_tick_i);
      n_rx_o <= n_rx_o + int'(rx_tick_i);
      n_clk_o <= n_clk_o + int'(clk_out_pin_i != clk_out_q);
    end
  end
endmodule : serial0_rate_gen_port_model

// ### tb/test_serial0_baud_rate_generator.sv
/*
  self-checking bench for serial0_rate_gen_top: a mode table counted over fixed windows,
  then reset, register and counter cases by hand. assumes serial0_rate_gen_pkg.
*/
`timescale 1ns/1ps
module test_serial0_baud_rate_generator
  import serial0_rate_gen_pkg::*;
;
  typedef struct packed {
    logic [2:0] mode;
    logic [4:0] cfg; // tx sel, rx sel, double, extra double, shift fast
    serial0_rate_gen_fn_t fn;
    logic [7:0] ntx;
    logic [7:0] nrx;
  } serial0_rate_gen_row_t;

  // reload 0xf0 on the undivided clock: one overflow every 16 cycles
  localparam serial0_rate_gen_row_t ROWS [13] = '{
    '{3'h0, 5'h00, SERIAL0_RATE_GEN_FN_SHIFT, 8'h40, 8'h40},
    '{3'h0, 5'h01, SERIAL0_RATE_GEN_FN_SHIFT, 8'hc0, 8'hc0},
    '{3'h0, 5'h10, SERIAL0_RATE_GEN_FN_SHIFT, 8'h30, 8'h30},
    '{3'h1, 5'h10, SERIAL0_RATE_GEN_FN_UART8, 8'h30, 8'h60},
    '{3'h3, 5'h08, SERIAL0_RATE_GEN_FN_UART9, 8'h60, 8'h30},
    '{3'h2, 5'h00, SERIAL0_RATE_GEN_FN_UART9, 8'h0c, 8'h0c},
    '{3'h2, 5'h06, SERIAL0_RATE_GEN_FN_UART9, 8'h60, 8'h60},
    '{3'h2, 5'h14, SERIAL0_RATE_GEN_FN_UART9, 8'h30, 8'h18},
    '{3'h2, 5'h0a, SERIAL0_RATE_GEN_FN_UART9, 8'h30, 8'h30},
    '{3'h2, 5'h18, SERIAL0_RATE_GEN_FN_TIMER, 8'h00, 8'h00},
    '{3'h4, 5'h00, SERIAL0_RATE_GEN_FN_SPI, 8'h40, 8'h40},
    '{3'h5, 5'h18, SERIAL0_RATE_GEN_FN_LIN, 8'h30, 8'h30},
    '{3'h7, 5'h00, SERIAL0_RATE_GEN_FN_RESERVED, 8'h00, 8'h00}
  };

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [3:0] sfr_page_i = 4'h0;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic ctrl1_access_sel_i = 1'b1;
  logic mode_bit_hi_i = 1'b0;
  logic mode_bit_mid_i = 1'b0;
  logic mode_bit_lo_i = 1'b0;
  logic baud_double_i = 1'b0;
  logic baud_extra_double_i = 1'b0;
  logic shift_fast_sel_i = 1'b0;
  logic timer_ovf_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic rate_gen_overflow_o;
  logic tx_tick_o;
  logic rx_tick_o;
  serial0_rate_gen_fn_t port_fn_o;
  logic auto_repeat_tx_en_o;
  logic auto_baud_en_o;
  logic clk_out_pin_o;
  logic clk_out_oe_o;
  logic [7:0] aux_pin_select_six_o;
  int n_ovf, n_tx, n_rx, n_clk, b_ovf, b_tx, b_rx, b_clk;
  int errors = 0;
  int n_compared = 0;
  logic [2:0] tcnt = 3'h0;
  logic [7:0] v, w;
  serial0_rate_gen_row_t r;

  // 20 ns period
  always #10 clk_i = ~clk_i;

  // neighbouring timer overflow, one pulse every 8 cycles
  always @(negedge clk_i) begin
    tcnt <= tcnt + 3'h1;
    timer_ovf_i <= (tcnt == 3'h0);
  end

  serial0_rate_gen_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .ctrl1_access_sel_i(ctrl1_access_sel_i), .mode_bit_hi_i(mode_bit_hi_i), .mode_bit_mid_i(mode_bit_mid_i),
    .mode_bit_lo_i(mode_bit_lo_i), .baud_double_i(baud_double_i), .baud_extra_double_i(baud_extra_double_i),
    .shift_fast_sel_i(shift_fast_sel_i), .timer_ovf_i(timer_ovf_i), .rate_gen_overflow_o(rate_gen_overflow_o),
    .tx_tick_o(tx_tick_o), .rx_tick_o(rx_tick_o), .port_fn_o(port_fn_o), .auto_repeat_tx_en_o(auto_repeat_tx_en_o),
    .auto_baud_en_o(auto_baud_en_o), .clk_out_pin_o(clk_out_pin_o), .clk_out_oe_o(clk_out_oe_o),
    .aux_pin_select_six_o(aux_pin_select_six_o));

  serial0_rate_gen_port_model model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ovf_i(rate_gen_overflow_o),
    .tx_tick_i(tx_tick_o), .rx_tick_i(rx_tick_o), .clk_out_pin_i(clk_out_pin_o),
    .n_ovf_o(n_ovf), .n_tx_o(n_tx), .n_rx_o(n_rx), .n_clk_o(n_clk));

  // one compare point so every check is counted the same way
  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_eq

  `define CHK(g, e) check_eq(32'(g), 32'(e));

  // one-cycle write strobe, an idle cycle follows
  task automatic sfr_wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_page_i = p;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask : sfr_wr

  // read data is registered, so sample a full cycle after the strobe
  task automatic sfr_rd(input logic [7:0] a, input logic [3:0] p, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_page_i = p;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    @(negedge clk_i);
    d = sfr_rdata_o;
  endtask : sfr_rd

  task automatic rd_chk(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
    logic [7:0] d;
    sfr_rd(a, p, d);
    check_eq(32'(d), 32'(e));
  endtask : rd_chk

  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    sfr_wr(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h0, 8'hf0);
    // mode table: windows are whole periods of every source, so counts are exact
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(negedge clk_i);
      {mode_bit_hi_i, mode_bit_mid_i, mode_bit_lo_i} = r.mode;
      {baud_double_i, baud_extra_double_i, shift_fast_sel_i} = r.cfg[2:0];
      sfr_wr(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, {2'b11, r.cfg[4:3], 4'h8});
      repeat (40) @(negedge clk_i);
      {b_ovf, b_tx, b_rx, b_clk} = {n_ovf, n_tx, n_rx, n_clk};
      repeat (768) @(negedge clk_i);
      `CHK(n_tx - b_tx, r.ntx)
      `CHK(n_rx - b_rx, r.nrx)
      `CHK(n_ovf - b_ovf, 8'h30)
      `CHK(n_clk - b_clk, 8'h30)
      `CHK(port_fn_o, r.fn)
      `CHK(auto_baud_en_o, r.fn == SERIAL0_RATE_GEN_FN_LIN)
    end
    // second reset in mid-run
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd_chk(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h0, SERIAL0_RATE_GEN_RST_RELOAD);
    rd_chk(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, SERIAL0_RATE_GEN_RST_COUNTER);
    rd_chk(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h5, SERIAL0_RATE_GEN_RST_CTRL1);
    rd_chk(SERIAL0_RATE_GEN_ADDR_AUX6, SERIAL0_RATE_GEN_PAGE_AUX6, SERIAL0_RATE_GEN_RST_AUX6);
    `CHK(clk_out_oe_o, 1'b0)
    // counter write leaves reload, stopped reload write loads counter
    sfr_wr(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, 8'h33);
    rd_chk(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h0, 8'h00);
    rd_chk(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, 8'h33);
    sfr_wr(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h0, 8'h77);
    rd_chk(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, 8'h77);
    sfr_wr(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h3, 8'h11);
    rd_chk(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h0, 8'h77);
    // reserved bits always written as zero, as software must
    sfr_wr(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'h3c);
    rd_chk(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'h3c);
    `CHK({auto_repeat_tx_en_o, clk_out_oe_o}, 2'h3)
    ctrl1_access_sel_i = 1'b0;
    sfr_wr(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'ha5);
    rd_chk(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'ha5);
    ctrl1_access_sel_i = 1'b1;
    rd_chk(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'h3c);
    sfr_wr(SERIAL0_RATE_GEN_ADDR_AUX6, SERIAL0_RATE_GEN_PAGE_AUX6, 8'h5a);
    rd_chk(SERIAL0_RATE_GEN_ADDR_AUX6, SERIAL0_RATE_GEN_PAGE_AUX6, 8'h5a);
    `CHK(aux_pin_select_six_o, 8'h5a)
    rd_chk(SERIAL0_RATE_GEN_ADDR_AUX6, 4'h0, 8'h00);
    // running on the divided clock: reload writes no longer touch the counter
    sfr_wr(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'h80);
    sfr_wr(SERIAL0_RATE_GEN_ADDR_RELOAD, 4'h0, 8'h10);
    sfr_rd(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, v);
    `CHK(v >= 8'h77 && v <= 8'h78, 1'b1)
    repeat (117) @(negedge clk_i);
    sfr_rd(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, w);
    `CHK((w - v) >= 8'h09 && (w - v) <= 8'h0b, 1'b1)
    // stopped counter holds
    sfr_wr(SERIAL0_RATE_GEN_ADDR_CTRL1, 4'h0, 8'h00);
    sfr_rd(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, v);
    repeat (50) @(negedge clk_i);
    rd_chk(SERIAL0_RATE_GEN_ADDR_COUNTER, 4'h0, v);
    tally_and_finish();
  end
endmodule : test_serial0_baud_rate_generator
